// ---- rtl/hw_port_pkg.sv ----
package hw_port_pkg;

   // Data widths of the host lanes and of internal storage
   localparam int HALF_W = 16;
   localparam int WORD_W = 32;
   // Host address pins A[7:1]: bit 0 of the field is the halfword select pin
   localparam int PA_W = 7;
   localparam int DW_W = PA_W - 1;
   localparam int HSEL_POS = 0;
   // Order setting value that selects the swapped mapping
   localparam logic [WORD_W-1:0] SWAP_ALL_ONES = 32'hffffffff;
   // Values after reset
   localparam logic [WORD_W-1:0] WORD_RST = 32'h00000000;
   localparam logic [HALF_W-1:0] HALF_RST = 16'h0000;
   localparam logic [DW_W-1:0] DW_RST = 6'h00;

   // Host pins as one carrier, so they pass the synchroniser together
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [PA_W-1:0] addr;
      logic [HALF_W-1:0] data;
   } host_pins_t;

   typedef enum logic {
      W_IDLE = 1'b0,
      W_HALF = 1'b1
   } wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_FETCH = 2'b01,
      RD_HOLD = 2'b10
   } rd_state_t;

   // Internal half (0 low, 1 high) that a host access reaches
   function automatic logic half_of(input logic hsel, input logic [WORD_W-1:0] cfg);
      half_of = hsel ^ (cfg == SWAP_ALL_ONES);
   endfunction : half_of

   // Halfword of a word picked by internal half
   function automatic logic [HALF_W-1:0] pick_half(input logic [WORD_W-1:0] w, input logic hi);
      pick_half = hi ? w[WORD_W-1:HALF_W] : w[HALF_W-1:0];
   endfunction : pick_half

endpackage : hw_port_pkg

// ---- rtl/pin_sync.sv ----
module pin_sync import hw_port_pkg::*; #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] value
);

   logic [W-1:0] s1_q, s1_d;
   logic [W-1:0] s2_q, s2_d;
   logic [W-1:0] s3_q, s3_d;
   logic [W-1:0] val_q, val_d;

   // A bit changes only once stages two and three agree
   always_comb begin
      s1_d = pin;
      s2_d = s1_q;
      s3_d = s2_q;
      for (int i = 0; i < W; i++) begin
         val_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : val_q[i];
      end
   end

   // Idle pins are high; all ones keeps strobes inactive out of reset
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         val_q <= '1;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         val_q <= val_d;
      end
   end

   assign value = val_q;

endmodule : pin_sync

// ---- rtl/halfword_host_port.sv ----
// What this block does
// - Write halves accepted in either order
// - Repeat write to same half discards doubleword
// - Same-half reread invalid, pairing restarts afterwards
// - Order setting maps lanes for registers, FIFOs
// - Default order: select low picks bytes 1:0
// - All-ones order: select low picks bytes 3:2
// - Network side always low halfword first
// - Internal storage is 32-bit words
module halfword_host_port import hw_port_pkg::*; (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic host_cs_n,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   input wire logic [PA_W-1:0] host_addr,
   input wire logic [HALF_W-1:0] host_data_in,
   output logic [HALF_W-1:0] host_data_out,
   output logic host_data_oe,
   input wire logic [WORD_W-1:0] word_swap_cfg,
   output logic [DW_W-1:0] int_addr,
   output logic int_wr,
   output logic [WORD_W-1:0] int_wdata,
   output logic int_rd,
   input wire logic [WORD_W-1:0] int_rdata,
   input wire logic tx_word_valid,
   input wire logic [WORD_W-1:0] tx_word,
   output logic tx_pop,
   output logic net_tx_valid,
   output logic [HALF_W-1:0] net_tx_half,
   input wire logic net_tx_ready,
   input wire logic net_rx_valid,
   input wire logic [HALF_W-1:0] net_rx_half,
   output logic rx_word_valid,
   output logic [WORD_W-1:0] rx_word
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and strobe edges

   host_pins_t raw_pins;
   host_pins_t pins;
   logic wr_act, rd_act;
   logic wr_prev_q, rd_prev_q;
   logic wr_take, rd_take;
   logic [DW_W-1:0] pin_dw;
   logic pin_half;

   assign raw_pins = '{cs_n: host_cs_n, rd_n: host_rd_n, wr_n: host_wr_n,
                       addr: host_addr, data: host_data_in};

   pin_sync #(.W($bits(host_pins_t))) u_sync (
      .mclk(mclk),
      .arst_n(arst_n),
      .pin(raw_pins),
      .value(pins)
   );

   // A strobe is taken on its synchronised leading edge
   assign wr_act = !pins.cs_n && !pins.wr_n;
   assign rd_act = !pins.cs_n && !pins.rd_n;
   assign wr_take = wr_act && !wr_prev_q;
   assign rd_take = rd_act && !rd_prev_q;
   assign pin_dw = pins.addr[PA_W-1:1];
   assign pin_half = half_of(pins.addr[HSEL_POS], word_swap_cfg);

   ////////////////////////////////////////////////////////////////////////////////
   // Host write and read pairing

   wr_state_t wst_q, wst_d;
   rd_state_t rst_q, rst_d;
   logic wr_hi_q, wr_hi_d;
   logic [DW_W-1:0] wr_dw_q, wr_dw_d;
   logic [HALF_W-1:0] wr_stage_q, wr_stage_d;
   logic rd_hi_q, rd_hi_d;
   logic [DW_W-1:0] rd_dw_q, rd_dw_d;
   logic [WORD_W-1:0] rd_word_q, rd_word_d;
   logic [DW_W-1:0] int_addr_q, int_addr_d;
   logic int_wr_q, int_wr_d;
   logic [WORD_W-1:0] int_wdata_q, int_wdata_d;
   logic int_rd_q, int_rd_d;
   logic [HALF_W-1:0] dout_q, dout_d;
   logic oe_q, oe_d;

   always_comb begin
      wst_d = wst_q;
      rst_d = rst_q;
      wr_hi_d = wr_hi_q;
      wr_dw_d = wr_dw_q;
      wr_stage_d = wr_stage_q;
      rd_hi_d = rd_hi_q;
      rd_dw_d = rd_dw_q;
      rd_word_d = rd_word_q;
      int_addr_d = int_addr_q;
      int_wr_d = 1'b0;
      int_wdata_d = int_wdata_q;
      int_rd_d = 1'b0;
      dout_d = dout_q;
      oe_d = rd_act;
      // stage first half, one word write on the second
      case (wst_q)
         W_IDLE: begin
            if (wr_take) begin
               wst_d = W_HALF;
               wr_hi_d = pin_half;
               wr_dw_d = pin_dw;
               wr_stage_d = pins.data;
            end
         end
         W_HALF: begin
            if (wr_take) begin
               // other half in either order completes the word
               if (pin_dw == wr_dw_q && pin_half != wr_hi_q) begin
                  wst_d = W_IDLE;
                  int_wr_d = 1'b1;
                  int_addr_d = pin_dw;
                  int_wdata_d = pin_half ? {pins.data, wr_stage_q} : {wr_stage_q, pins.data};
               end else if (pin_dw == wr_dw_q) begin
                  // same half again, whole doubleword dropped
                  wst_d = W_IDLE;
               end else begin
                  // Host broke the aligned pair; start over from this half
                  wr_hi_d = pin_half;
                  wr_dw_d = pin_dw;
                  wr_stage_d = pins.data;
               end
            end
         end
         default: wst_d = W_IDLE;
      endcase
      // one 32-bit internal read serves both host halves
      case (rst_q)
         RD_IDLE: begin
            if (rd_take) begin
               rst_d = RD_FETCH;
               int_rd_d = 1'b1;
               int_addr_d = pin_dw;
               rd_hi_d = pin_half;
               rd_dw_d = pin_dw;
            end
         end
         RD_FETCH: begin
            // Read data is taken in the same cycle as the internal read pulse
            rst_d = RD_HOLD;
            rd_word_d = int_rdata;
            dout_d = pick_half(int_rdata, rd_hi_q);
         end
         RD_HOLD: begin
            if (rd_take) begin
               if (rd_dw_q == pin_dw && rd_hi_q != pin_half) begin
                  rst_d = RD_IDLE;
                  dout_d = pick_half(rd_word_q, pin_half);
               end else if (rd_dw_q == pin_dw) begin
                  // stale data returned, next read starts a fresh pair
                  rst_d = RD_IDLE;
               end else begin
                  // A new doubleword replaces the unfinished pair
                  rst_d = RD_FETCH;
                  int_rd_d = 1'b1;
                  int_addr_d = pin_dw;
                  rd_hi_d = pin_half;
                  rd_dw_d = pin_dw;
               end
            end
         end
         default: rst_d = RD_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wr_prev_q <= 1'b0;
         rd_prev_q <= 1'b0;
         wst_q <= W_IDLE;
         rst_q <= RD_IDLE;
         wr_hi_q <= 1'b0;
         wr_dw_q <= DW_RST;
         wr_stage_q <= HALF_RST;
         rd_hi_q <= 1'b0;
         rd_dw_q <= DW_RST;
         rd_word_q <= WORD_RST;
         int_addr_q <= DW_RST;
         int_wr_q <= 1'b0;
         int_wdata_q <= WORD_RST;
         int_rd_q <= 1'b0;
         dout_q <= HALF_RST;
         oe_q <= 1'b0;
      end else begin
         wr_prev_q <= wr_act;
         rd_prev_q <= rd_act;
         wst_q <= wst_d;
         rst_q <= rst_d;
         wr_hi_q <= wr_hi_d;
         wr_dw_q <= wr_dw_d;
         wr_stage_q <= wr_stage_d;
         rd_hi_q <= rd_hi_d;
         rd_dw_q <= rd_dw_d;
         rd_word_q <= rd_word_d;
         int_addr_q <= int_addr_d;
         int_wr_q <= int_wr_d;
         int_wdata_q <= int_wdata_d;
         int_rd_q <= int_rd_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
      end
   end

   assign int_addr = int_addr_q;
   assign int_wr = int_wr_q;
   assign int_wdata = int_wdata_q;
   assign int_rd = int_rd_q;
   assign host_data_out = dout_q;
   assign host_data_oe = oe_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Network halfword order, independent of the host order setting

   logic tx_busy_q, tx_busy_d;
   logic tx_ph_q, tx_ph_d;
   logic [WORD_W-1:0] tx_w_q, tx_w_d;
   logic tx_pop_q, tx_pop_d;
   logic [HALF_W-1:0] tx_half_q, tx_half_d;
   logic rx_ph_q, rx_ph_d;
   logic [HALF_W-1:0] rx_lo_q, rx_lo_d;
   logic rx_vld_q, rx_vld_d;
   logic [WORD_W-1:0] rx_word_q, rx_word_d;

   always_comb begin
      tx_busy_d = tx_busy_q;
      tx_ph_d = tx_ph_q;
      tx_w_d = tx_w_q;
      tx_pop_d = 1'b0;
      tx_half_d = tx_half_q;
      rx_ph_d = rx_ph_q;
      rx_lo_d = rx_lo_q;
      rx_vld_d = 1'b0;
      rx_word_d = rx_word_q;
      // low half leaves first; word popped with the first half
      if (!tx_busy_q && tx_word_valid) begin
         tx_busy_d = 1'b1;
         tx_ph_d = 1'b0;
         tx_w_d = tx_word;
         tx_pop_d = 1'b1;
         tx_half_d = tx_word[HALF_W-1:0];
      end else if (tx_busy_q && net_tx_ready) begin
         tx_ph_d = 1'b1;
         tx_half_d = tx_w_q[WORD_W-1:HALF_W];
         tx_busy_d = !tx_ph_q;
      end
      // first received half fills the low half
      if (net_rx_valid) begin
         rx_ph_d = !rx_ph_q;
         if (!rx_ph_q) begin
            rx_lo_d = net_rx_half;
         end else begin
            rx_vld_d = 1'b1;
            rx_word_d = {net_rx_half, rx_lo_q};
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_busy_q <= 1'b0;
         tx_ph_q <= 1'b0;
         tx_w_q <= WORD_RST;
         tx_pop_q <= 1'b0;
         tx_half_q <= HALF_RST;
         rx_ph_q <= 1'b0;
         rx_lo_q <= HALF_RST;
         rx_vld_q <= 1'b0;
         rx_word_q <= WORD_RST;
      end else begin
         tx_busy_q <= tx_busy_d;
         tx_ph_q <= tx_ph_d;
         tx_w_q <= tx_w_d;
         tx_pop_q <= tx_pop_d;
         tx_half_q <= tx_half_d;
         rx_ph_q <= rx_ph_d;
         rx_lo_q <= rx_lo_d;
         rx_vld_q <= rx_vld_d;
         rx_word_q <= rx_word_d;
      end
   end

   assign tx_pop = tx_pop_q;
   assign net_tx_valid = tx_busy_q;
   assign net_tx_half = tx_half_q;
   assign rx_word_valid = rx_vld_q;
   assign rx_word = rx_word_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence s_second_other;
      wst_q == W_HALF && wr_take && pin_dw == wr_dw_q && pin_half != wr_hi_q;
   endsequence

   a_wr_commit_pair: assert property (int_wr_q |-> $past(wst_q) == W_HALF)
      else $error("internal write without a staged half");
   a_wr_other_half: assert property (s_second_other |=> int_wr_q && wst_q == W_IDLE)
      else $error("second write half not committed");
   a_wr_same_drop: assert property (wst_q == W_HALF && wr_take && pin_dw == wr_dw_q
      && pin_half == wr_hi_q |=> !int_wr_q && wst_q == W_IDLE)
      else $error("same-half write was not discarded");
   a_lane_default: assert property (s_second_other and (word_swap_cfg != SWAP_ALL_ONES
      && !pins.addr[HSEL_POS]) |=> int_wdata_q[15:0] == $past(pins.data))
      else $error("default lane map wrong");
   a_lane_swap: assert property (s_second_other and (word_swap_cfg == SWAP_ALL_ONES
      && !pins.addr[HSEL_POS]) |=> int_wdata_q[31:16] == $past(pins.data))
      else $error("swapped lane map wrong");
   a_rd_fetch_once: assert property (rst_q == RD_IDLE && rd_take
      |=> int_rd_q ##1 !int_rd_q && rst_q == RD_HOLD)
      else $error("read pair did not fetch one word");
   a_rd_same_restart: assert property (rst_q == RD_HOLD && rd_take && pin_dw == rd_dw_q
      && pin_half == rd_hi_q |=> rst_q == RD_IDLE && !int_rd_q)
      else $error("same-half read did not restart pairing");
   // Tie the popped word back to the FIFO input, not to our own copy
   a_tx_low_first: assert property (tx_pop_q |-> net_tx_valid
      && net_tx_half == tx_w_q[15:0] && tx_w_q == $past(tx_word))
      else $error("transmit did not start with low half");
   a_rx_low_first: assert property (rx_vld_q |-> rx_word_q[31:16] == $past(net_rx_half)
      && rx_word_q[15:0] == $past(rx_lo_q))
      else $error("first received half not in low half");

endmodule : halfword_host_port

// ---- verif/host_model.sv ----
module host_model import hw_port_pkg::*; (
   input wire logic mclk,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [PA_W-1:0] addr,
   output logic [HALF_W-1:0] data,
   input wire logic [HALF_W-1:0] data_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 7'h00;
      data = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // whole address held while strobe low
   // Strobe low 10 cycles, gap 6: both above the synchroniser's needs
   task automatic cycle(input logic wr, input logic [PA_W-1:0] a,
                        input logic [HALF_W-1:0] d, output logic [HALF_W-1:0] q);
      @(negedge mclk);
      addr = a;
      data = d;
      cs_n = 1'b0;
      rd_n = wr;
      wr_n = !wr;
      repeat (10) @(negedge mclk);
      q = data_out;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      // Released lanes show no stale value
      data = ~d;
      repeat (6) @(negedge mclk);
   endtask : cycle
endmodule : host_model

// ---- verif/testbench.sv ----
module testbench import hw_port_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic cs_n, rd_n, wr_n, oe, int_wr, int_rd, tx_pop, net_tx_valid, rx_word_valid;
   logic [PA_W-1:0] addr;
   logic [HALF_W-1:0] din, dout, net_tx_half;
   logic [HALF_W-1:0] net_rx_half = 16'h0000;
   logic [WORD_W-1:0] cfg = 32'h0, tx_word = 32'h0, int_wdata, int_rdata, rx_word;
   logic [WORD_W-1:0] wword, rword;
   logic [DW_W-1:0] int_addr, waddr;
   logic tx_word_valid = 1'b0;
   logic net_tx_ready = 1'b0;
   logic net_rx_valid = 1'b0;
   int errors = 0, n_tests = 0, n_wr = 0, n_rd = 0, n_rx = 0, n_oe = 0;

   always #12.5 mclk = ~mclk;

   host_model host (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .data(din), .data_out(dout));

   halfword_host_port dut (.mclk(mclk), .arst_n(arst_n), .host_cs_n(cs_n),
      .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr(addr), .host_data_in(din),
      .host_data_out(dout), .host_data_oe(oe), .word_swap_cfg(cfg), .int_addr(int_addr),
      .int_wr(int_wr), .int_wdata(int_wdata), .int_rd(int_rd), .int_rdata(int_rdata),
      .tx_word_valid(tx_word_valid), .tx_word(tx_word), .tx_pop(tx_pop),
      .net_tx_valid(net_tx_valid), .net_tx_half(net_tx_half), .net_tx_ready(net_tx_ready),
      .net_rx_valid(net_rx_valid), .net_rx_half(net_rx_half),
      .rx_word_valid(rx_word_valid), .rx_word(rx_word));

   ////////////////////////////////////////////////////////////////////////
   // Register file stand-in: word tied to its address, valid while held
   function automatic logic [WORD_W-1:0] rw(input logic [DW_W-1:0] a);
      rw = {10'h3c1, a, 10'h1a5, a};
   endfunction : rw
   assign int_rdata = rw(int_addr);

   // Pulses counted mid-cycle, clear of the launching edge
   always @(negedge mclk) begin
      if (int_wr === 1'b1) begin
         n_wr++;
         wword = int_wdata;
         waddr = int_addr;
      end
      if (int_rd === 1'b1) n_rd++;
      // Cycles in which the port drives the lanes
      if (oe === 1'b1) n_oe++;
      if (rx_word_valid === 1'b1) begin
         n_rx++;
         rword = rx_word;
      end
   end

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask : chk

   task automatic hw(input logic [PA_W-1:0] a, input logic [HALF_W-1:0] d);
      logic [HALF_W-1:0] q;
      host.cycle(1'b1, a, d, q);
   endtask : hw

   ////////////////////////////////////////////////////////////////////////
   // Writes in both orders under three order settings
   task automatic t_write();
      logic [WORD_W-1:0] cfgs [3] = '{32'h0, 32'hfffffffe, 32'hffffffff};
      logic [HALF_W-1:0] d0, d1;
      logic [DW_W-1:0] dw;
      int k;
      for (int i = 0; i < 3; i++) begin
         cfg = cfgs[i];
         dw = 6'(5 + i);
         k = n_wr;
         hw({dw, i[0]}, 16'h1234 + 16'(i));
         chk("no early commit", 32'(k), 32'(n_wr));
         hw({dw, !i[0]}, 16'hbeef);
         d0 = i[0] ? 16'hbeef : 16'h1234 + 16'(i);
         d1 = i[0] ? 16'h1234 + 16'(i) : 16'hbeef;
         chk("int_wr count", 32'(k + 1), 32'(n_wr));
         chk("int_addr", 32'(dw), 32'(waddr));
         chk("int_wdata", (i == 2) ? {d0, d1} : {d1, d0}, wword);
      end
      $display("test write done");
   endtask : t_write

   // Same half twice drops the pair; a fresh pair then commits
   task automatic t_wr_same();
      int k;
      cfg = 32'h0;
      k = n_wr;
      hw({6'h11, 1'b0}, 16'h0aaa);
      hw({6'h11, 1'b0}, 16'h0bbb);
      chk("discarded write", 32'(k), 32'(n_wr));
      hw({6'h11, 1'b1}, 16'h0ccc);
      hw({6'h11, 1'b0}, 16'h0ddd);
      chk("write after discard", 32'(k + 1), 32'(n_wr));
      chk("int_wdata", 32'h0ccc0ddd, wword);
      $display("test repeated write done");
   endtask : t_wr_same

   // Reads high select first, both order settings
   task automatic t_read();
      logic [HALF_W-1:0] q0, q1;
      logic [DW_W-1:0] dw;
      logic [WORD_W-1:0] w;
      int k, m;
      for (int i = 0; i < 2; i++) begin
         cfg = i ? 32'hffffffff : 32'h0;
         dw = 6'(9 + i);
         w = rw(dw);
         k = n_rd;
         m = n_oe;
         host.cycle(1'b0, {dw, 1'b1}, 16'h0, q1);
         host.cycle(1'b0, {dw, 1'b0}, 16'h0, q0);
         chk("int_rd count", 32'(k + 1), 32'(n_rd));
         // Lanes driven 10 cycles for each 10-cycle read strobe, one cycle behind the synchronised strobe
         chk("host_data_oe cycles", 32'(m + 20), 32'(n_oe));
         chk("read hi sel", 32'(i ? w[15:0] : w[31:16]), 32'(q1));
         chk("read lo sel", 32'(i ? w[31:16] : w[15:0]), 32'(q0));
      end
      $display("test read done");
   endtask : t_read

   // Repeated half read restarts pairing with a new fetch
   task automatic t_rd_same();
      logic [HALF_W-1:0] q, q0, q1;
      int k;
      cfg = 32'h0;
      k = n_rd;
      host.cycle(1'b0, {6'h21, 1'b0}, 16'h0, q);
      host.cycle(1'b0, {6'h21, 1'b0}, 16'h0, q);
      host.cycle(1'b0, {6'h21, 1'b0}, 16'h0, q0);
      host.cycle(1'b0, {6'h21, 1'b1}, 16'h0, q1);
      chk("refetch count", 32'(k + 2), 32'(n_rd));
      chk("refetch data", rw(6'h21), {q1, q0});
      $display("test repeated read done");
   endtask : t_rd_same

   // Transmit word leaves low half first, stalled by the network
   task automatic t_tx();
      @(negedge mclk);
      tx_word = 32'h5a5ac3c3;
      tx_word_valid = 1'b1;
      for (int i = 0; i < 10 && tx_pop !== 1'b1; i++) @(negedge mclk);
      tx_word_valid = 1'b0;
      chk("tx_pop", 32'h1, 32'(tx_pop));
      repeat (2) @(negedge mclk);
      chk("tx low half", 32'h1c3c3, {15'h0, net_tx_valid, net_tx_half});
      net_tx_ready = 1'b1;
      @(negedge mclk);
      net_tx_ready = 1'b0;
      chk("tx high half", 32'h15a5a, {15'h0, net_tx_valid, net_tx_half});
      net_tx_ready = 1'b1;
      @(negedge mclk);
      net_tx_ready = 1'b0;
      chk("tx idle", 32'h0, 32'(net_tx_valid));
      $display("test transmit done");
   endtask : t_tx

   // Back to back received halves, first one lands low
   task automatic t_rx();
      int k;
      k = n_rx;
      for (int i = 0; i < 4; i++) begin
         @(negedge mclk);
         net_rx_valid = 1'b1;
         net_rx_half = 16'h1000 * 16'(i + 1);
      end
      @(negedge mclk);
      net_rx_valid = 1'b0;
      net_rx_half = 16'hbfff;
      repeat (3) @(negedge mclk);
      chk("rx count", 32'(k + 2), 32'(n_rx));
      chk("rx_word", 32'h40003000, rword);
      $display("test receive done");
   endtask : t_rx

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge mclk);
      arst_n = 1'b1;
      repeat (2) @(negedge mclk);
      t_write();
      t_wr_same();
      t_read();
      t_rd_same();
      t_tx();
      t_rx();
      test_done();
   end

   // Tests need about 300 cycles; far above that means a hang
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      test_done();
   end
endmodule : testbench
